// file: hw/fcep_regs.svh
// Register offsets, field positions, reset values and command codes of the flash error-protection block
`ifndef FCEP_REGS_SVH
`define FCEP_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define FCEP_OFS_MODE_ENTRY  12'h000
`define FCEP_OFS_ACCESS_STAT 12'h004
`define FCEP_OFS_IRQ_ENABLE  12'h008
`define FCEP_OFS_SEQ_STATUS  12'h00C
`define FCEP_OFS_START_ADDR  12'h010
`define FCEP_OFS_END_ADDR    12'h014
`define FCEP_OFS_CONTROL     12'h018
`define FCEP_OFS_CMD_WINDOW  12'h100

// ****************************************
// Field positions
// ****************************************
`define FCEP_AST_CODE_ERR  0
`define FCEP_AST_DATA_ERR  1
`define FCEP_AST_LOCK      4
`define FCEP_IEN_LOCK      4
`define FCEP_SST_TBL_ECC   8
`define FCEP_SST_CFG_ECC   9
`define FCEP_SST_OTP_ECC   10
`define FCEP_SST_SUSPENDED 11
`define FCEP_SST_PRG_ERR   12
`define FCEP_SST_ERS_ERR   13
`define FCEP_SST_ILGL_ERR  14
`define FCEP_SST_READY     15
`define FCEP_CTL_BC_DIR    0
`define FCEP_CTL_PROT_OVR  1

// ****************************************
// Reset values and mode settings
// ****************************************
`define FCEP_RST_MODE  16'h0000
`define FCEP_RST_ADDR  32'h0000_0000
`define FCEP_MODE_READ 16'h0000
`define FCEP_MODE_CODE 16'h0001
`define FCEP_MODE_DATA 16'h0080

// ****************************************
// Command codes
// ****************************************
`define FCEP_CMD_PROGRAM   8'hE8
`define FCEP_CMD_DMA_PROG  8'hEA
`define FCEP_CMD_ERASE     8'h20
`define FCEP_CMD_LOCK_PROG 8'h77
`define FCEP_CMD_BLANK     8'h73
`define FCEP_CMD_CONFIG    8'h40
`define FCEP_CMD_OTP       8'h45
`define FCEP_CMD_SUSPEND   8'hB0
`define FCEP_CMD_RESUME    8'hD0
`define FCEP_CMD_CLEAR     8'h50
`define FCEP_CMD_STOP      8'hB3
`define FCEP_CMD_FINAL     8'hD0

`endif

// file: hw/fcep_pkg.sv
// Types shared by the flash error-protection block
package fcep_pkg;

   // Command sequencer states, Gray coded along the usual path
   typedef enum logic [1:0] {
      FCEP_IDLE  = 2'b00,
      FCEP_CODE  = 2'b01,
      FCEP_DATA  = 2'b11,
      FCEP_FINAL = 2'b10
   } fcep_seq_t;

   // Request towards the flash array engine
   typedef struct packed {
      logic start;
      logic suspend;
      logic resume;
      logic abort;
      logic [7:0] cmd;
      logic [7:0] words;
   } fcep_array_req_t;

   // Whole state of the block
   typedef struct packed {
      logic [15:0] mode;
      logic [15:0] susp_mode;
      logic [31:0] start_addr;
      logic [31:0] end_addr;
      logic bc_dir;
      logic prot_ovr;
      logic irq_en;
      logic code_err;
      logic data_err;
      logic lock;
      logic ilgl;
      logic ers;
      logic prg;
      logic otp_ecc;
      logic cfg_ecc;
      logic tbl_ecc;
      logic busy;
      logic susp_pend;
      logic susp;
      logic [7:0] cur_cmd;
      fcep_seq_t seq;
      logic [7:0] cmd;
      logic [7:0] cnt;
      logic [7:0] nwords;
      logic [31:0] rdata;
      logic irq;
      fcep_array_req_t req;
   } fcep_state_t;

endpackage

// file: hw/fcep_top.sv
// Flash sequencer error protection: command checking, command lock, status flags and APB registers
`timescale 1ns/10ps
`include "fcep_regs.svh"

module fcep_top #(
   parameter logic [7:0] PROG_WORDS = 8'h02, // Word count for a programming command
   parameter logic [7:0] CFG_WORDS = 8'h08, // Word count for a configuration command
   parameter logic [7:0] OTP_WORDS = 8'h08 // Word count for an OTP setting command
) (
   input wire logic pclk, // Bus clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction, high for write
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped address
   input wire logic id_unlocked, // ID authentication has unlocked security
   input wire logic tgt_reserved, // Start address lies in a reserved area
   input wire logic tgt_otp, // Start address lies in an OTP block
   input wire logic tgt_locked, // Target block has its lock bit set
   input wire logic vector_in_otp, // Configuration places the reset vector in OTP
   input wire logic array_done, // Pulse: array operation ended or suspended
   input wire logic array_fail, // With array_done: operation failed
   input wire logic ecc_otp_err, // Pulse: double-bit error reading OTP settings
   input wire logic ecc_cfg_err, // Pulse: double-bit error reading configuration
   input wire logic ecc_tbl_err, // Pulse: double-bit error reading parameter table
   output fcep_pkg::fcep_array_req_t array_req, // Request to the array engine
   output logic [31:0] cmd_start_addr, // Start address for the address map
   output logic [31:0] cmd_end_addr, // End address for the address map
   output logic access_error_irq // Interrupt, level
);

   fcep_pkg::fcep_state_t s_q;
   fcep_pkg::fcep_state_t s_d;

   logic acc;
   logic wr;
   logic rd;
   logic win;
   logic mapped;
   logic [7:0] wd;
   logic blank_ok;

   // True for commands that run a program or erase on the array
   function automatic logic is_pe(input logic [7:0] c);
      return c == `FCEP_CMD_PROGRAM || c == `FCEP_CMD_DMA_PROG || c == `FCEP_CMD_ERASE ||
             c == `FCEP_CMD_LOCK_PROG;
   endfunction

   // True for every code the sequencer knows as a first write
   function automatic logic is_known(input logic [7:0] c);
      return is_pe(c) || c == `FCEP_CMD_BLANK || c == `FCEP_CMD_CONFIG || c == `FCEP_CMD_OTP ||
             c == `FCEP_CMD_SUSPEND || c == `FCEP_CMD_RESUME || c == `FCEP_CMD_CLEAR ||
             c == `FCEP_CMD_STOP;
   endfunction

   // True for commands that carry a word count in their second write
   function automatic logic has_count(input logic [7:0] c);
      return c == `FCEP_CMD_PROGRAM || c == `FCEP_CMD_DMA_PROG || c == `FCEP_CMD_CONFIG ||
             c == `FCEP_CMD_OTP;
   endfunction

   // ****************************************
   // Bus decode
   // ****************************************
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign win = paddr == `FCEP_OFS_CMD_WINDOW;
   assign wd = pwdata[7:0];
   assign mapped = win || paddr == `FCEP_OFS_MODE_ENTRY || paddr == `FCEP_OFS_ACCESS_STAT ||
                   paddr == `FCEP_OFS_IRQ_ENABLE || paddr == `FCEP_OFS_SEQ_STATUS ||
                   paddr == `FCEP_OFS_START_ADDR || paddr == `FCEP_OFS_END_ADDR ||
                   paddr == `FCEP_OFS_CONTROL;
   // Blank check direction 0 walks upward, 1 walks downward
   assign blank_ok = s_q.bc_dir ? (s_q.start_addr >= s_q.end_addr) : (s_q.start_addr <= s_q.end_addr);

   // Zero wait states keep the bus simple; read data is captured in the setup cycle
   assign pready = 1'b1;
   assign pslverr = acc && !mapped;
   assign prdata = s_q.rdata;
   assign array_req = s_q.req;
   assign cmd_start_addr = s_q.start_addr;
   assign cmd_end_addr = s_q.end_addr;
   assign access_error_irq = s_q.irq;

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      logic lock_it;
      logic dfin;
      lock_it = 1'b0;
      dfin = 1'b0;
      s_d = s_q;
      s_d.req.start = 1'b0;
      s_d.req.suspend = 1'b0;
      s_d.req.resume = 1'b0;
      s_d.req.abort = 1'b0;

      // Read data prepared in the setup cycle
      if (psel && !penable && !pwrite) begin
         case (paddr)
            `FCEP_OFS_MODE_ENTRY: s_d.rdata = {16'h0000, s_q.mode};
            `FCEP_OFS_ACCESS_STAT: begin
               s_d.rdata = 32'h0000_0000;
               s_d.rdata[`FCEP_AST_CODE_ERR] = s_q.code_err;
               s_d.rdata[`FCEP_AST_DATA_ERR] = s_q.data_err;
               s_d.rdata[`FCEP_AST_LOCK] = s_q.lock;
            end
            `FCEP_OFS_IRQ_ENABLE: begin
               s_d.rdata = 32'h0000_0000;
               s_d.rdata[`FCEP_IEN_LOCK] = s_q.irq_en;
            end
            `FCEP_OFS_SEQ_STATUS: begin
               s_d.rdata = 32'h0000_0000;
               s_d.rdata[`FCEP_SST_TBL_ECC] = s_q.tbl_ecc;
               s_d.rdata[`FCEP_SST_CFG_ECC] = s_q.cfg_ecc;
               s_d.rdata[`FCEP_SST_OTP_ECC] = s_q.otp_ecc;
               s_d.rdata[`FCEP_SST_SUSPENDED] = s_q.susp;
               s_d.rdata[`FCEP_SST_PRG_ERR] = s_q.prg;
               s_d.rdata[`FCEP_SST_ERS_ERR] = s_q.ers;
               s_d.rdata[`FCEP_SST_ILGL_ERR] = s_q.ilgl;
               s_d.rdata[`FCEP_SST_READY] = !s_q.busy;
            end
            `FCEP_OFS_START_ADDR: s_d.rdata = s_q.start_addr;
            `FCEP_OFS_END_ADDR: s_d.rdata = s_q.end_addr;
            `FCEP_OFS_CONTROL: begin
               s_d.rdata = 32'h0000_0000;
               s_d.rdata[`FCEP_CTL_BC_DIR] = s_q.bc_dir;
               s_d.rdata[`FCEP_CTL_PROT_OVR] = s_q.prot_ovr;
            end
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end

      // Plain register writes; area errors clear by writing zero
      if (wr) begin
         case (paddr)
            `FCEP_OFS_MODE_ENTRY: s_d.mode = pwdata[15:0];
            `FCEP_OFS_ACCESS_STAT: begin
               s_d.code_err = s_q.code_err && pwdata[`FCEP_AST_CODE_ERR];
               s_d.data_err = s_q.data_err && pwdata[`FCEP_AST_DATA_ERR];
            end
            `FCEP_OFS_IRQ_ENABLE: s_d.irq_en = pwdata[`FCEP_IEN_LOCK];
            `FCEP_OFS_START_ADDR: s_d.start_addr = pwdata;
            `FCEP_OFS_END_ADDR: s_d.end_addr = pwdata;
            `FCEP_OFS_CONTROL: begin
               s_d.bc_dir = pwdata[`FCEP_CTL_BC_DIR];
               s_d.prot_ovr = pwdata[`FCEP_CTL_PROT_OVR];
            end
            default: ;
         endcase
      end

      // Any read of the command window is illegal in every mode
      if (rd && win) begin
         lock_it = 1'b1;
      end else if (wr && win) begin
         if (s_q.lock) begin
            // Only a clear or stop may leave the lock, and only with both area errors at zero
            if (wd == `FCEP_CMD_STOP && !s_q.code_err && !s_q.data_err) begin
               dfin = 1'b1;
               s_d.req.abort = s_q.busy || s_q.susp;
               s_d.busy = 1'b0;
               s_d.susp = 1'b0;
               s_d.susp_pend = 1'b0;
            end else if (wd == `FCEP_CMD_CLEAR && !s_q.busy && !s_q.code_err && !s_q.data_err) begin
               dfin = 1'b1;
            end else begin
               // Suspend is refused here too, so an interrupted operation runs to its end
               s_d.ilgl = 1'b1;
               s_d.seq = fcep_pkg::FCEP_IDLE;
            end
            if (dfin) begin
               s_d.lock = 1'b0;
               s_d.ilgl = 1'b0;
               s_d.ers = 1'b0;
               s_d.prg = 1'b0;
               s_d.otp_ecc = 1'b0;
               s_d.cfg_ecc = 1'b0;
               s_d.tbl_ecc = 1'b0;
               s_d.seq = fcep_pkg::FCEP_IDLE;
            end
         end else if (s_q.mode == `FCEP_MODE_READ) begin
            lock_it = 1'b1;
         end else if (s_q.mode != `FCEP_MODE_CODE && s_q.mode != `FCEP_MODE_DATA) begin
            lock_it = 1'b1;
         end else begin
            case (s_q.seq)
               fcep_pkg::FCEP_IDLE: begin
                  if (!is_known(wd)) begin
                     lock_it = 1'b1;
                  end else if (wd == `FCEP_CMD_STOP) begin
                     s_d.req.abort = s_q.busy || s_q.susp;
                     s_d.busy = 1'b0;
                     s_d.susp = 1'b0;
                     s_d.susp_pend = 1'b0;
                  end else if (wd == `FCEP_CMD_CLEAR) begin
                     if (s_q.busy) begin
                        lock_it = 1'b1;
                     end else begin
                        s_d.ilgl = 1'b0;
                        s_d.ers = 1'b0;
                        s_d.prg = 1'b0;
                        s_d.otp_ecc = 1'b0;
                        s_d.cfg_ecc = 1'b0;
                        s_d.tbl_ecc = 1'b0;
                     end
                  end else if (wd == `FCEP_CMD_SUSPEND) begin
                     if (s_q.busy && !s_q.susp_pend && is_pe(s_q.cur_cmd)) begin
                        s_d.req.suspend = 1'b1;
                        s_d.susp_pend = 1'b1;
                        s_d.susp_mode = s_q.mode;
                     end else begin
                        lock_it = 1'b1;
                     end
                  end else if (wd == `FCEP_CMD_RESUME) begin
                     if (!s_q.susp) begin
                        lock_it = 1'b1;
                     end else if (s_q.mode != s_q.susp_mode) begin
                        lock_it = 1'b1;
                     end else begin
                        s_d.req.resume = 1'b1;
                        s_d.susp = 1'b0;
                        s_d.busy = 1'b1;
                     end
                  end else if (s_q.busy || s_q.susp) begin
                     lock_it = 1'b1;
                  end else if (wd == `FCEP_CMD_LOCK_PROG && s_q.mode != `FCEP_MODE_CODE) begin
                     lock_it = 1'b1;
                  end else if ((s_q.mode == `FCEP_MODE_CODE || wd == `FCEP_CMD_CONFIG) && !id_unlocked) begin
                     lock_it = 1'b1;
                  end else begin
                     s_d.cmd = wd;
                     s_d.seq = fcep_pkg::FCEP_CODE;
                  end
               end
               fcep_pkg::FCEP_CODE: begin
                  if (has_count(s_q.cmd)) begin
                     s_d.nwords = wd;
                     s_d.cnt = wd;
                     if (s_q.cmd == `FCEP_CMD_DMA_PROG) begin
                        if (wd == 8'h00 || wd[0]) begin
                           lock_it = 1'b1;
                        end else begin
                           dfin = 1'b1; // DMA carries its data itself and has no final D0
                        end
                     end else if ((s_q.cmd == `FCEP_CMD_PROGRAM && wd != PROG_WORDS) ||
                                  (s_q.cmd == `FCEP_CMD_CONFIG && wd != CFG_WORDS) ||
                                  (s_q.cmd == `FCEP_CMD_OTP && wd != OTP_WORDS)) begin
                        lock_it = 1'b1;
                     end else begin
                        s_d.seq = fcep_pkg::FCEP_DATA;
                     end
                  end else if (wd != `FCEP_CMD_FINAL) begin
                     lock_it = 1'b1;
                  end else begin
                     dfin = 1'b1;
                  end
               end
               fcep_pkg::FCEP_DATA: begin
                  // Data words go to the array engine's own buffer; only the count is kept here
                  s_d.cnt = s_q.cnt - 8'h01;
                  if (s_q.cnt == 8'h01) begin
                     s_d.seq = fcep_pkg::FCEP_FINAL;
                  end
               end
               fcep_pkg::FCEP_FINAL: begin
                  if (wd != `FCEP_CMD_FINAL) begin
                     lock_it = 1'b1;
                  end else begin
                     dfin = 1'b1;
                  end
               end
               default: s_d.seq = fcep_pkg::FCEP_IDLE;
            endcase

            // Checks on the target made once the command is complete
            if (dfin) begin
               s_d.seq = fcep_pkg::FCEP_IDLE;
               if (tgt_reserved && (s_q.cmd == `FCEP_CMD_CONFIG || s_q.cmd == `FCEP_CMD_OTP ||
                                    s_q.mode == `FCEP_MODE_DATA)) begin
                  lock_it = 1'b1;
                  s_d.data_err = 1'b1;
               end else if (tgt_reserved) begin
                  lock_it = 1'b1;
                  s_d.code_err = 1'b1;
               end else if ((is_pe(s_q.cmd) && s_q.cmd != `FCEP_CMD_DMA_PROG || s_q.cmd == `FCEP_CMD_DMA_PROG)
                            && tgt_otp) begin
                  lock_it = 1'b1;
               end else if (s_q.cmd == `FCEP_CMD_CONFIG && vector_in_otp) begin
                  lock_it = 1'b1;
               end else if (s_q.cmd == `FCEP_CMD_BLANK && !blank_ok) begin
                  lock_it = 1'b1;
               end else if (s_q.cmd == `FCEP_CMD_ERASE && tgt_locked && !s_q.prot_ovr) begin
                  s_d.lock = 1'b1;
                  s_d.ers = 1'b1;
               end else if ((s_q.cmd == `FCEP_CMD_PROGRAM || s_q.cmd == `FCEP_CMD_DMA_PROG ||
                             s_q.cmd == `FCEP_CMD_LOCK_PROG) && tgt_locked && !s_q.prot_ovr) begin
                  s_d.lock = 1'b1;
                  s_d.prg = 1'b1;
               end else begin
                  // Start happens only on this unlocked path
                  s_d.req.start = 1'b1;
                  s_d.req.cmd = s_q.cmd;
                  s_d.req.words = (s_q.cmd == `FCEP_CMD_DMA_PROG) ? wd : s_q.nwords;
                  s_d.cur_cmd = s_q.cmd;
                  s_d.busy = 1'b1;
               end
            end
         end
      end

      // Illegal command lock sets only the illegal flag; a lock never stops a running operation
      if (lock_it) begin
         s_d.lock = 1'b1;
         s_d.ilgl = 1'b1;
         s_d.seq = fcep_pkg::FCEP_IDLE;
      end

      // Array completion; hardware events are applied last so they win over a clear
      if (array_done && s_q.busy) begin
         s_d.busy = 1'b0;
         s_d.susp = s_q.susp_pend && !array_fail;
         s_d.susp_pend = 1'b0;
         if (array_fail) begin
            s_d.lock = 1'b1;
            if (s_q.cur_cmd == `FCEP_CMD_ERASE) begin
               s_d.ers = 1'b1;
            end else begin
               s_d.prg = 1'b1;
            end
         end
      end
      // Double-bit ECC errors count as a sequencer malfunction
      if (ecc_otp_err || ecc_cfg_err || ecc_tbl_err) begin
         s_d.lock = 1'b1;
      end
      if (ecc_otp_err) begin
         s_d.otp_ecc = 1'b1;
      end
      if (ecc_cfg_err) begin
         s_d.cfg_ecc = 1'b1;
      end
      if (ecc_tbl_err) begin
         s_d.tbl_ecc = 1'b1;
      end

      // Interrupt stands while locked and enabled
      s_d.irq = s_d.lock && s_d.irq_en;
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.mode <= `FCEP_RST_MODE;
         s_q.susp_mode <= `FCEP_RST_MODE;
         s_q.start_addr <= `FCEP_RST_ADDR;
         s_q.end_addr <= `FCEP_RST_ADDR;
         s_q.seq <= fcep_pkg::FCEP_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

endmodule // fcep_top

// file: verif/fcep_chk.sv
// Assertion checker for the flash error-protection block
`timescale 1ns/10ps
module fcep_chk (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, active low
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Direction
   input wire logic [11:0] paddr, // Address
   input wire logic [31:0] pwdata, // Write data
   input wire logic pslverr, // Bus error
   input wire logic ecc_otp_err, // ECC pulse
   input wire fcep_pkg::fcep_array_req_t array_req, // Array request
   input wire logic access_error_irq // Interrupt
);
   logic en_q;
   wire acc = psel & penable;
   wire win = acc & (paddr == 12'h100);
   // Shadow of the lock interrupt enable, so lock can be seen through the interrupt
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) en_q <= 1'b0;
      else if (acc && pwrite && paddr == 12'h008) en_q <= pwdata[4];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   win_read_lock_a: assert property (win && !pwrite && en_q |=> access_error_irq) else $error("window read no lock");
   ecc_lock_a: assert property (ecc_otp_err && en_q |=> access_error_irq) else $error("ecc no lock");
   lock_no_start_a: assert property (access_error_irq |-> !array_req.start) else $error("start while locked");
   start_cause_a: assert property (array_req.start |-> $past(win && pwrite)) else $error("start without write");
   start_pulse_a: assert property (array_req.start |=> !array_req.start) else $error("start too long");
   // Only a window command or an enable write may drop the interrupt
   irq_fall_a: assert property ($fell(access_error_irq) |-> $past(acc && pwrite && (paddr[8] || paddr[3])))
      else $error("lock left without command");
   unmapped_err_a: assert property (acc && paddr == 12'h01C |-> pslverr) else $error("unmapped not refused");
   window_ok_a: assert property (win |-> !pslverr) else $error("window refused");
   cover property (array_req.start);
   cover property ($rose(access_error_irq));
   cover property (acc && pslverr);
endmodule // fcep_chk

bind fcep_top fcep_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
   .ecc_otp_err, .array_req, .access_error_irq);

// file: verif/fcep_top_test.sv
// Self-checking bench for the flash error-protection block
`timescale 1ns/10ps
module fcep_top_test;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, pready, pslverr, irq;
   logic id_ok = 1, rsv = 0, lkd = 0, done = 0, fail = 0, otp = 0, vec = 0;
   logic [2:0] ecc = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rv, sa, ea, a;
   logic [7:0] lcmd;
   logic [15:0] m;
   logic [15:0] bad [4] = '{16'h1111, 16'h2055, 16'hE803, 16'hEA03};
   fcep_pkg::fcep_array_req_t req;
   int num_errors = 0, checks = 0, starts = 0, susps = 0;
   always #25 pclk = ~pclk;
   fcep_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .id_unlocked(id_ok), .tgt_reserved(rsv), .tgt_otp(otp), .tgt_locked(lkd), .vector_in_otp(vec),
      .array_done(done), .array_fail(fail), .ecc_otp_err(ecc[2]), .ecc_cfg_err(ecc[1]), .ecc_tbl_err(ecc[0]),
      .array_req(req), .cmd_start_addr(sa), .cmd_end_addr(ea), .access_error_irq(irq));
   // Count array requests; a locked block must not launch work
   always @(posedge pclk) begin
      starts <= starts + req.start;
      susps <= susps + req.suspend;
      if (req.start) lcmd <= req.cmd;
   end
   // ****************************************
   // Bus and checking tasks
   // ****************************************
   task automatic chk(input string n, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", n, e, g);
         num_errors++;
      end
   endtask
   // Master holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // Expected status word from {ready, illegal, erase, program, suspended, otp, cfg, table}
   function automatic logic [31:0] st(input logic [7:0] f);
      return {16'h0000, f, 8'h00};
   endfunction
   task automatic cw(input logic [7:0] c); apb(1, 12'h100, {24'h0, c}); endtask
   task automatic cs(input logic [7:0] f); apb(0, 12'h00C, 0); chk("status", st(f), rv); endtask
   task automatic ci(input logic e); @(negedge pclk); chk("irq", e, irq); endtask
   task automatic pulse(input logic [4:0] v);
      @(posedge pclk);
      {done, fail, ecc} <= v;
      @(posedge pclk);
      {done, fail, ecc} <= 0;
   endtask
   task automatic print_verdict;
      if (num_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Watchdog far beyond the expected few hundred cycles
   initial begin
      #500000;
      num_errors++;
      print_verdict;
   end
   // Main sequence
   initial begin
      m = $urandom(32'h6582F80F);
      repeat (12) @(posedge pclk);
      presetn <= 1;
      cs(8'h80);
      apb(0, 12'h01C, 0);
      chk("slverr", 1, err);
      apb(1, 12'h008, 32'h10);
      cw(8'h20);
      ci(1);
      cs(8'hC0);
      cw(8'h20);
      cs(8'hC0);
      apb(1, 12'h000, 32'h80);
      cw(8'h50);
      ci(0);
      cs(8'h80);
      repeat (4) begin
         m = $urandom;
         if (m == 0 || m == 1 || m == 16'h80) m = 16'h1234;
         apb(1, 12'h000, {16'h0, m});
         cw(8'h50);
         cs(8'hC0);
         apb(1, 12'h000, 32'h80);
         cw(8'hB3);
      end
      apb(1, 12'h000, 32'h1);
      lkd <= 1;
      cw(8'h20);
      cw(8'hD0);
      cs(8'hA0);
      cw(8'hB3);
      lkd <= 0;
      cw(8'h20);
      cw(8'hD0);
      cs(8'h00);
      pulse(5'b11000);
      cs(8'hA0);
      cw(8'hB3);
      // Program with two random data words, which the array then fails
      cw(8'hE8);
      cw(8'h02);
      repeat (2) cw(8'($urandom));
      cw(8'hD0);
      pulse(5'b11000);
      chk("cmd", 32'h0000_00E8, lcmd);
      cs(8'h90);
      cw(8'h50);
      cs(8'h80);
      foreach (bad[i]) begin
         cw(bad[i][15:8]);
         cw(bad[i][7:0]);
         cs(8'hC0);
         cw(8'hB3);
      end
      apb(0, 12'h100, 0);
      cs(8'hC0);
      cw(8'hB3);
      id_ok <= 0;
      cw(8'h20);
      id_ok <= 1;
      cs(8'hC0);
      cw(8'hB3);
      rsv <= 1;
      cw(8'h20);
      cw(8'hD0);
      rsv <= 0;
      apb(0, 12'h004, 0);
      chk("area", 32'h11, rv);
      cw(8'hB3);
      cs(8'hC0);
      apb(1, 12'h004, 0);
      cw(8'hB3);
      cs(8'h80);
      // Reserved target in data mode flags the data area instead
      apb(1, 12'h000, 32'h80);
      rsv <= 1;
      cw(8'h20);
      cw(8'hD0);
      rsv <= 0;
      apb(0, 12'h004, 0);
      chk("area", 32'h12, rv);
      apb(1, 12'h004, 0);
      cw(8'hB3);
      apb(1, 12'h000, 32'h1);
      otp <= 1;
      cw(8'h20);
      cw(8'hD0);
      otp <= 0;
      cs(8'hC0);
      cw(8'hB3);
      vec <= 1;
      cw(8'h40);
      cw(8'h08);
      repeat (8) cw(8'($urandom));
      cw(8'hD0);
      vec <= 0;
      cs(8'hC0);
      cw(8'hB3);
      // Odd random start above the end makes an upward blank check inconsistent
      a = $urandom | 32'h1;
      apb(1, 12'h010, a);
      apb(1, 12'h014, a - 32'h1);
      chk("start", a, sa);
      cw(8'h73);
      chk("end", a - 32'h1, ea);
      cw(8'hD0);
      cs(8'hC0);
      cw(8'hB3);
      cw(8'h20);
      cw(8'hD0);
      cw(8'h11);
      cw(8'hB0);
      cs(8'h40);
      pulse(5'b10000);
      cs(8'hC0);
      chk("suspend", 0, susps);
      cw(8'hB3);
      // Suspend an erase, change the mode entry, then try to resume
      cw(8'h20);
      cw(8'hD0);
      cw(8'hB0);
      pulse(5'b10000);
      apb(1, 12'h000, 32'h80);
      cw(8'hD0);
      cs(8'hC8);
      chk("suspend", 1, susps);
      cw(8'hB3);
      for (int i = 0; i < 3; i++) begin
         pulse(5'b00001 << i);
         cs(8'h80 | (8'h01 << i));
         cw(8'h50);
      end
      chk("starts", 4, starts);
      print_verdict;
   end
endmodule // fcep_top_test
